// ===== dv/mcu_io_ports_tb_top.sv
// Self-checking testbench of the parallel I/O port block
`timescale 1ns/1ps
`default_nettype none
module mcu_io_ports_tb_top
    import mio_pkg::*;
;
    // ========================================================
    // Stimulus and observation signals
    localparam int RST_CYC = 4;
    logic        i_clock = 1'b0;
    logic        i_rst   = 1'b1;
    logic [7:0]  addr    = 8'h00;
    logic [7:0]  wdata   = 8'h00;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [7:0]  pin_i   = 8'h00;
    logic        rc      = 1'b0;
    logic        fault   = 1'b0;
    logic        hwake   = 1'b0;
    logic        iwake   = 1'b0;
    logic [7:0]  ext_val = 8'h00;
    logic [7:0]  rdata, d_out, mwu, l_pins, c_pins, g_pins;
    logic [7:0]  l_out, l_oe, l_pu, c_out, c_oe, c_pu, g_out, g_oe, g_pu;
    logic        rvalid, hit, alt_ph;
    logic [1:0]  mode;
    logic [12:0] alt;
    int          err_count = 0;
    int          checked   = 0;
    int          seed      = 32'h149e;
    logic [8:0]  exp_q[$];

    // ========================================================
    // Clock, design and pin models
    initial forever #4 i_clock = ~i_clock;

    mio_io_ports #(.RESTART_CYCLES(RST_CYC)) dut_u (
        .i_clock(i_clock), .i_rst(i_rst), .i_mem_addr(addr),
        .i_mem_wdata(wdata), .i_mem_wr(wr), .i_mem_rd(rd),
        .o_mem_rdata(rdata), .o_mem_rvalid(rvalid), .o_mem_hit(hit),
        .i_port_l_pins(l_pins), .o_port_l_out(l_out), .o_port_l_oe(l_oe),
        .o_port_l_pullup(l_pu), .i_port_c_pins(c_pins),
        .o_port_c_out(c_out), .o_port_c_oe(c_oe), .o_port_c_pullup(c_pu),
        .i_port_g_pins(g_pins), .o_port_g_out(g_out), .o_port_g_oe(g_oe),
        .o_port_g_pullup(g_pu), .i_port_i_pins(pin_i), .o_port_d(d_out),
        .i_rc_osc_option(rc), .i_supervisor_fault_output(fault),
        .i_halt_wakeup(hwake), .i_idle_wakeup(iwake), .o_power_mode(mode),
        .o_sync_serial_alt_phase(alt_ph), .o_multi_input_wakeup(mwu),
        .o_serial_ext_clock(alt[12]), .o_serial_receive_pin(alt[11]),
        .o_timer2_input_a(alt[10]), .o_timer2_input_b(alt[9]),
        .o_timer3_input_a(alt[8]), .o_timer3_input_b(alt[7]),
        .o_sync_serial_data_in(alt[6]), .o_sync_serial_clock(alt[5]),
        .o_timer1_io(alt[4]), .o_timer1_capture_input(alt[3]),
        .o_external_interrupt_input(alt[2]),
        .o_comparator_one_output(alt[1]), .o_comparator_two_output(alt[0]));

    mio_pin_model l_pm (.i_clock(i_clock), .i_out(l_out), .i_oe(l_oe),
        .i_pullup(l_pu), .i_ext_en(8'hff), .i_ext_val(ext_val),
        .o_pins(l_pins));
    mio_pin_model c_pm (.i_clock(i_clock), .i_out(c_out), .i_oe(c_oe),
        .i_pullup(c_pu), .i_ext_en(8'hff), .i_ext_val(~ext_val),
        .o_pins(c_pins));
    mio_pin_model g_pm (.i_clock(i_clock), .i_out(g_out), .i_oe(g_oe),
        .i_pullup(g_pu), .i_ext_en(8'hff), .i_ext_val(ext_val),
        .o_pins(g_pins));

    // ========================================================
    // Compare, bus and closing tasks
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge i_clock);
        wr = 1'b0;
    endtask : wr_reg

    // Expected answer is queued; the monitor below compares it
    task automatic rd_reg(input logic [7:0] a, input logic [8:0] e);
        @(negedge i_clock);
        addr = a;
        rd = 1'b1;
        exp_q.push_back(e);
        @(negedge i_clock);
        rd = 1'b0;
    endtask : rd_reg

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    function automatic logic [12:0] alt_exp(input logic [7:0] l, g, i);
        return {l[1], l[3], l[4], l[5], l[6], l[7],
                g[6], g[5], g[3], g[2], g[0], i[3], i[6]};
    endfunction : alt_exp

    // Read answers: oldest note against each valid pulse
    always @(posedge i_clock) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0)
                chk("stray read", 16'h0000, 16'hffff);
            else
                chk("read data", 16'(exp_q.pop_front()), {hit, rdata});
        end
    end

    // Watchdog, sized well beyond the whole sequence
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end

    // ========================================================
    // Main sequence
    initial begin
        logic [7:0] cfg, dat;
        int n;
        repeat (6) @(negedge i_clock);
        chk("d in reset", 16'h00ff, d_out);
        chk("lc drive", 16'h0000, {l_oe | l_pu, c_oe | c_pu});
        i_rst = 1'b0;
        rd_reg(ADDR_L_CFG, 9'h100);
        rd_reg(ADDR_G_DATA, 9'h100);
        rd_reg(ADDR_C_CFG, 9'h100);
        // Random set-ups; C takes the swapped pair to show independence
        for (n = 0; n < 8; n++) begin
            cfg = 8'($random(seed));
            dat = 8'($random(seed));
            wr_reg(ADDR_L_CFG, cfg);
            wr_reg(ADDR_L_DATA, dat);
            wr_reg(ADDR_C_CFG, dat);
            wr_reg(ADDR_C_DATA, cfg);
            wr_reg(ADDR_G_CFG, cfg & 8'h7f);
            wr_reg(ADDR_G_DATA, dat & 8'h3f);
            chk("l oe", cfg, l_oe);
            chk("l out", cfg & dat, l_out & cfg);
            chk("l pull", ~cfg & dat, l_pu);
            chk("c oe pull", {dat, ~dat & cfg}, {c_oe, c_pu});
            chk("g oe", cfg & 8'h3d, g_oe & 8'h3d);
            chk("g pull", ~cfg & dat & 8'h3d, g_pu & 8'h3d);
            chk("alt phase", cfg[6], alt_ph);
            chk("c g out", {cfg, dat & 8'h3d}, {c_out, g_out});
            rd_reg(ADDR_L_DATA, {1'b1, dat});
            rd_reg(ADDR_C_CFG, {1'b1, dat});
            rd_reg(ADDR_G_CFG, {1'b1, cfg & 8'h7f});
        end
        // Pins: L drives a5, C and G released to the outside world
        wr_reg(ADDR_L_CFG, 8'hff);
        wr_reg(ADDR_L_DATA, 8'ha5);
        wr_reg(ADDR_C_CFG, 8'h00);
        wr_reg(ADDR_C_DATA, 8'h00);
        wr_reg(ADDR_G_CFG, 8'h00);
        wr_reg(ADDR_G_DATA, 8'h00);
        for (n = 0; n < 4; n++) begin
            ext_val = 8'($random(seed));
            pin_i = 8'($random(seed));
            repeat (3) @(negedge i_clock);
            chk("alternates", alt_exp(l_pins, g_pins, pin_i), alt);
            chk("wakeup pins", l_pins, mwu);
            // A pin-location write must leave the driven L pins alone
            wr_reg(ADDR_L_PIN, 8'h5a);
            rd_reg(ADDR_L_PIN, 9'h1a5);
            rd_reg(ADDR_C_PIN, {1'b1, ~ext_val});
            rd_reg(ADDR_I_PIN, {1'b1, pin_i});
            wr_reg(ADDR_G_PIN, ~ext_val);
            rd_reg(ADDR_G_PIN, {1'b1, ext_val});
        end
        rd_reg(8'hd3, 9'h000);
        dat = 8'($random(seed));
        wr_reg(ADDR_D_DATA, dat);
        chk("port d", dat, d_out);
        // Fault output on G1 pulls low
        fault = 1'b1;
        repeat (2) @(negedge i_clock);
        chk("g1 fault", 16'h0002, {g_oe[1], g_out[1]});
        fault = 1'b0;
        // Halt and idle entry and exit
        wr_reg(ADDR_G_DATA, 8'h80);
        chk("halt", MIO_HALT, mode);
        rd_reg(ADDR_G_DATA, 9'h100);
        hwake = 1'b1;
        @(negedge i_clock);
        hwake = 1'b0;
        chk("halt exit", MIO_RUN, mode);
        wr_reg(ADDR_G_DATA, 8'h40);
        chk("idle", MIO_IDLE, mode);
        iwake = 1'b1;
        @(negedge i_clock);
        iwake = 1'b0;
        chk("idle exit", MIO_RUN, mode);
        // RC option: G7 rising edge leaves halt through the delay
        rc = 1'b1;
        ext_val = 8'h00;
        wr_reg(ADDR_G_CFG, 8'h80);
        repeat (3) @(negedge i_clock);
        wr_reg(ADDR_G_DATA, 8'h80);
        repeat (4) @(negedge i_clock);
        chk("halt holds", MIO_HALT, mode);
        ext_val = 8'h80;
        n = 0;
        while (mode !== MIO_RESTART && n < 10) begin
            @(negedge i_clock);
            n++;
        end
        n = 0;
        while (mode === MIO_RESTART && n < 20) begin
            @(negedge i_clock);
            n++;
        end
        chk("restart span", 16'(RST_CYC), 16'(n));
        chk("after restart", MIO_RUN, mode);
        // Reset in mid-run acts at once
        repeat (2) @(negedge i_clock);
        i_rst = 1'b1;
        #1;
        chk("d reset", 16'h00ff, d_out);
        chk("l reset", 16'h0000, {l_oe, l_pu});
        end_of_test();
    end
endmodule : mcu_io_ports_tb_top
`default_nettype wire

// ===== dv/mio_pin_model.sv
// Pin-side model of one two-way port: resolves the level on each wire
`timescale 1ns/1ps
`default_nettype none
module mio_pin_model (
    input  wire logic       i_clock,
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_pullup,
    input  wire logic [7:0] i_ext_en,
    input  wire logic [7:0] i_ext_val,
    output logic      [7:0] o_pins
);
    // ========================================================
    // Wire resolution
    logic [7:0] last_r = 8'h00;

    // A floating wire flips every cycle so a stale level never passes
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (i_oe[b])
                o_pins[b] = i_out[b];
            else if (i_ext_en[b])
                o_pins[b] = i_ext_val[b];
            else if (i_pullup[b])
                o_pins[b] = 1'b1;
            else
                o_pins[b] = ~last_r[b];
        end
    end

    // Last level, kept for the floating case
    always_ff @(posedge i_clock) begin
        last_r <= o_pins;
    end
endmodule : mio_pin_model
`default_nettype wire

// ===== shared/mio_pkg.sv
// Shared constants, types and helpers of the parallel I/O port block
package mio_pkg;

    // ========================================================
    // Data-memory locations of the ports
    localparam logic [7:0] ADDR_L_DATA = 8'hd0;
    localparam logic [7:0] ADDR_L_CFG  = 8'hd1;
    localparam logic [7:0] ADDR_L_PIN  = 8'hd2;
    localparam logic [7:0] ADDR_G_DATA = 8'hd4;
    localparam logic [7:0] ADDR_G_CFG  = 8'hd5;
    localparam logic [7:0] ADDR_G_PIN  = 8'hd6;
    localparam logic [7:0] ADDR_I_PIN  = 8'hd7;
    localparam logic [7:0] ADDR_C_DATA = 8'hd8;
    localparam logic [7:0] ADDR_C_CFG  = 8'hd9;
    localparam logic [7:0] ADDR_C_PIN  = 8'hda;
    localparam logic [7:0] ADDR_D_DATA = 8'hdc;

    // ========================================================
    // Values after reset
    localparam logic [7:0] PORT_RESET   = 8'h00;
    localparam logic [7:0] D_RESET      = 8'hff;

    // ========================================================
    // Port G field positions and masks
    localparam int         G_HALT_BIT   = 7;
    localparam int         G_IDLE_BIT   = 6;
    localparam int         G_ALT_BIT    = 6;
    localparam int         G_DLY_BIT    = 7;
    localparam int         G_RC_PIN_BIT = 7;
    localparam logic [7:0] G_IO_MASK    = 8'h3d;
    localparam logic [7:0] G_FAULT_MASK = 8'h02;
    localparam logic [7:0] G_SPEC_MASK  = 8'hc0;

    // Pin bit positions of alternate functions
    localparam int L_EXT_CLK  = 1;
    localparam int L_RX       = 3;
    localparam int L_T2A      = 4;
    localparam int L_T2B      = 5;
    localparam int L_T3A      = 6;
    localparam int L_T3B      = 7;
    localparam int G_INT      = 0;
    localparam int G_T1_CAP   = 2;
    localparam int G_T1_IO    = 3;
    localparam int G_SER_CLK  = 5;
    localparam int G_SER_IN   = 6;
    localparam int I_CMP1_OUT = 3;
    localparam int I_CMP2_OUT = 6;

    // Clock start-up delay after halt, in cycles
    localparam int RESTART_CYCLES_DEF = 256;

    // ========================================================
    // Power mode
    typedef enum logic [1:0] {
        MIO_RUN     = 2'b00,
        MIO_HALT    = 2'b01,
        MIO_IDLE    = 2'b10,
        MIO_RESTART = 2'b11
    } mio_mode_t;

    // Weak pull-up on where configured as input with data one
    function automatic logic [7:0] mio_pull(input logic [7:0] cfg,
                                           input logic [7:0] dat);
        mio_pull = ~cfg & dat;
    endfunction : mio_pull

endpackage : mio_pkg

// ===== verilog/mio_io_ports.sv
// Parallel I/O ports L, G, C, I and D on the data-memory bus
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Config/data pair selects pin drive mode
// - Each two-way port: config, data, pin
// - Every bit configured independently of others
// - G data bit 7 write enters halt
// - G data bit 6 write enters idle
// - G config bit 6 selects alternate serial phase
// - RC option with G config 7: restart delay
// - G data bits 6, 7 read zero
// - G: five I/O, input 6, fault output 1
// - RC option: G7 rising edge leaves halt
// - Missing C pins read undefined values
// - Port I eight input bits, comparator pins
// - Port D outputs high during reset
// - All L pins feed wakeup; L1, L3-L7 feed alternates
// - Port G alternate pins for serial, timer
// - Reset clears L, G, C registers
module mio_io_ports
    import mio_pkg::*;
#(
    parameter int RESTART_CYCLES = RESTART_CYCLES_DEF
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_mem_addr,
    input  wire logic [7:0] i_mem_wdata,
    input  wire logic       i_mem_wr,
    input  wire logic       i_mem_rd,
    output logic      [7:0] o_mem_rdata,
    output logic            o_mem_rvalid,
    output logic            o_mem_hit,
    input  wire logic [7:0] i_port_l_pins,
    output logic      [7:0] o_port_l_out,
    output logic      [7:0] o_port_l_oe,
    output logic      [7:0] o_port_l_pullup,
    input  wire logic [7:0] i_port_c_pins,
    output logic      [7:0] o_port_c_out,
    output logic      [7:0] o_port_c_oe,
    output logic      [7:0] o_port_c_pullup,
    input  wire logic [7:0] i_port_g_pins,
    output logic      [7:0] o_port_g_out,
    output logic      [7:0] o_port_g_oe,
    output logic      [7:0] o_port_g_pullup,
    input  wire logic [7:0] i_port_i_pins,
    output logic      [7:0] o_port_d,
    input  wire logic       i_rc_osc_option,
    input  wire logic       i_supervisor_fault_output,
    input  wire logic       i_halt_wakeup,
    input  wire logic       i_idle_wakeup,
    output logic      [1:0] o_power_mode,
    output logic            o_sync_serial_alt_phase,
    output logic      [7:0] o_multi_input_wakeup,
    output logic            o_serial_ext_clock,
    output logic            o_serial_receive_pin,
    output logic            o_timer2_input_a,
    output logic            o_timer2_input_b,
    output logic            o_timer3_input_a,
    output logic            o_timer3_input_b,
    output logic            o_sync_serial_data_in,
    output logic            o_sync_serial_clock,
    output logic            o_timer1_io,
    output logic            o_timer1_capture_input,
    output logic            o_external_interrupt_input,
    output logic            o_comparator_one_output,
    output logic            o_comparator_two_output
);

    // ========================================================
    // Elaboration checks
    if (RESTART_CYCLES < 1 || RESTART_CYCLES > 65536) begin : g_chk
        $error("RESTART_CYCLES must lie in 1..65536");
    end

    // ========================================================
    // State
    typedef struct packed {
        logic [7:0]  l_cfg;
        logic [7:0]  l_dat;
        logic [7:0]  l_pull;
        logic [7:0]  c_cfg;
        logic [7:0]  c_dat;
        logic [7:0]  c_pull;
        logic [7:0]  g_cfg;
        logic [7:0]  g_dat;
        logic [7:0]  g_oe;
        logic [7:0]  g_out;
        logic [7:0]  g_pull;
        logic [7:0]  d_dat;
        mio_mode_t   mode;
        logic [15:0] cnt;
        logic        g7_prev;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        hit;
    } mio_state_t;

    // Ports L, G, C come up as high-impedance inputs, D high
    localparam mio_state_t ST_RESET = '{
        l_cfg: PORT_RESET, l_dat: PORT_RESET, l_pull: PORT_RESET,
        c_cfg: PORT_RESET, c_dat: PORT_RESET, c_pull: PORT_RESET,
        g_cfg: PORT_RESET, g_dat: PORT_RESET, g_oe: PORT_RESET,
        g_out: PORT_RESET, g_pull: PORT_RESET, d_dat: D_RESET,
        mode: MIO_RUN, cnt: 16'h0000, g7_prev: 1'b0,
        rdata: 8'h00, rvalid: 1'b0, hit: 1'b0};

    localparam logic [15:0] RESTART_LOAD = 16'(RESTART_CYCLES - 1);

    mio_state_t  st_r;
    mio_state_t  st_nxt;
    logic [32:0] pins_sync;
    logic [7:0]  l_pin;
    logic [7:0]  c_pin;
    logic [7:0]  g_pin;
    logic [7:0]  i_pin;
    logic        rc_opt;
    logic        g7_rise;
    logic        halt_wake;

    // ========================================================
    // Pin synchronisers; all later logic sees only stage two
    mio_pin_sync #(
        .WIDTH (33)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async ({i_rc_osc_option, i_port_i_pins, i_port_g_pins,
                   i_port_c_pins, i_port_l_pins}),
        .o_sync  (pins_sync)
    );

    assign l_pin  = pins_sync[7:0];
    assign c_pin  = pins_sync[15:8];   // Unbonded C bits float
    assign g_pin  = pins_sync[23:16];
    assign i_pin  = pins_sync[31:24];  // Input only
    assign rc_opt = pins_sync[32];

    // RC option turns G7 into a halt restart input
    assign g7_rise   = g_pin[G_RC_PIN_BIT] & ~st_r.g7_prev;
    assign halt_wake = i_halt_wakeup | (rc_opt & g7_rise);

    // ========================================================
    // Next state: bus writes, power mode, reads, pin drive
    always_comb begin
        st_nxt         = st_r;
        st_nxt.rvalid  = 1'b0;
        st_nxt.hit     = 1'b0;
        st_nxt.g7_prev = g_pin[G_RC_PIN_BIT];

        // Byte writes; bit ops are read-modify-write
        if (i_mem_wr) begin
            case (i_mem_addr)
                ADDR_L_DATA: st_nxt.l_dat = i_mem_wdata;
                ADDR_L_CFG:  st_nxt.l_cfg = i_mem_wdata;
                ADDR_C_DATA: st_nxt.c_dat = i_mem_wdata;
                ADDR_C_CFG:  st_nxt.c_cfg = i_mem_wdata;
                ADDR_G_DATA: st_nxt.g_dat = i_mem_wdata;
                ADDR_G_CFG:  st_nxt.g_cfg = i_mem_wdata;
                ADDR_D_DATA: st_nxt.d_dat = i_mem_wdata;
                // Pin locations take no write
                default: ;
            endcase
        end

        // Power mode; halt outranks idle when both bits are written
        case (st_r.mode)
            MIO_RUN: begin
                if (i_mem_wr && i_mem_addr == ADDR_G_DATA) begin
                    if (i_mem_wdata[G_HALT_BIT]) begin
                        st_nxt.mode = MIO_HALT;
                    end else if (i_mem_wdata[G_IDLE_BIT]) begin
                        st_nxt.mode = MIO_IDLE;
                    end
                end
            end
            MIO_HALT: begin
                if (halt_wake) begin
                    if (rc_opt && st_r.g_cfg[G_DLY_BIT]) begin
                        st_nxt.mode = MIO_RESTART;
                        st_nxt.cnt  = RESTART_LOAD;
                    end else begin
                        st_nxt.mode = MIO_RUN;
                    end
                end
            end
            MIO_IDLE: begin
                if (i_idle_wakeup) begin
                    st_nxt.mode = MIO_RUN;
                end
            end
            MIO_RESTART: begin
                // Oscillator settles before the core is released
                if (st_r.cnt == 16'h0000) begin
                    st_nxt.mode = MIO_RUN;
                end else begin
                    st_nxt.cnt = st_r.cnt - 16'h0001;
                end
            end
            default: st_nxt.mode = MIO_RUN;
        endcase

        // Read answer one cycle after the strobe
        if (i_mem_rd) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.hit    = 1'b1;
            case (i_mem_addr)
                ADDR_L_DATA: st_nxt.rdata = st_r.l_dat;
                ADDR_L_CFG:  st_nxt.rdata = st_r.l_cfg;
                ADDR_L_PIN:  st_nxt.rdata = l_pin;
                ADDR_C_DATA: st_nxt.rdata = st_r.c_dat;
                ADDR_C_CFG:  st_nxt.rdata = st_r.c_cfg;
                ADDR_C_PIN:  st_nxt.rdata = c_pin;
                // Special bits act as commands
                ADDR_G_DATA: st_nxt.rdata = st_r.g_dat & ~G_SPEC_MASK;
                ADDR_G_CFG:  st_nxt.rdata = st_r.g_cfg;
                ADDR_G_PIN:  st_nxt.rdata = g_pin;
                ADDR_I_PIN:  st_nxt.rdata = i_pin;
                ADDR_D_DATA: st_nxt.rdata = st_r.d_dat;
                default: begin
                    st_nxt.rdata = 8'h00;
                    st_nxt.hit   = 1'b0;
                end
            endcase
        end

        // Pin drive from the new config/data pairs
        st_nxt.l_pull = mio_pull(st_nxt.l_cfg, st_nxt.l_dat);
        st_nxt.c_pull = mio_pull(st_nxt.c_cfg, st_nxt.c_dat);
        // G1 pulls low only on a fault, G6/G7 never driven
        st_nxt.g_oe   = (st_nxt.g_cfg & G_IO_MASK)
                      | (i_supervisor_fault_output ? G_FAULT_MASK : 8'h00);
        st_nxt.g_out  = st_nxt.g_dat & G_IO_MASK;
        st_nxt.g_pull = mio_pull(st_nxt.g_cfg, st_nxt.g_dat) & G_IO_MASK;
    end

    // Clears L, G, C and presets D; and
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================================
    // Outputs, all straight from flip-flops
    assign o_mem_rdata      = st_r.rdata;
    assign o_mem_rvalid     = st_r.rvalid;
    assign o_mem_hit        = st_r.hit;
    assign o_port_l_out     = st_r.l_dat;
    assign o_port_l_oe      = st_r.l_cfg;
    assign o_port_l_pullup  = st_r.l_pull;
    assign o_port_c_out     = st_r.c_dat;
    assign o_port_c_oe      = st_r.c_cfg;
    assign o_port_c_pullup  = st_r.c_pull;
    assign o_port_g_out     = st_r.g_out;
    assign o_port_g_oe      = st_r.g_oe;
    assign o_port_g_pullup  = st_r.g_pull;
    assign o_port_d         = st_r.d_dat;
    assign o_power_mode     = st_r.mode;
    assign o_sync_serial_alt_phase = st_r.g_cfg[G_ALT_BIT];

    // Alternate functions take the synchronised pin levels
    assign o_multi_input_wakeup = l_pin;
    assign o_serial_ext_clock   = l_pin[L_EXT_CLK];
    assign o_serial_receive_pin = l_pin[L_RX];
    assign o_timer2_input_a     = l_pin[L_T2A];
    assign o_timer2_input_b     = l_pin[L_T2B];
    assign o_timer3_input_a     = l_pin[L_T3A];
    assign o_timer3_input_b     = l_pin[L_T3B];
    assign o_sync_serial_data_in  = g_pin[G_SER_IN];
    assign o_sync_serial_clock    = g_pin[G_SER_CLK];
    assign o_timer1_io            = g_pin[G_T1_IO];
    assign o_timer1_capture_input = g_pin[G_T1_CAP];
    assign o_external_interrupt_input = g_pin[G_INT];
    assign o_comparator_one_output = i_pin[I_CMP1_OUT];
    assign o_comparator_two_output = i_pin[I_CMP2_OUT];

    // ========================================================
    // Assertions
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence g_data_wr_s;
        i_mem_wr && i_mem_addr == ADDR_G_DATA;
    endsequence

    sequence halt_exit_s;
        o_power_mode == MIO_HALT && halt_wake;
    endsequence

    halt_enter_a: assert property (
        (o_power_mode == MIO_RUN) and g_data_wr_s
        and i_mem_wdata[G_HALT_BIT] |=> o_power_mode == MIO_HALT)
        else $error("halt bit write did not enter halt");

    idle_enter_a: assert property (
        (o_power_mode == MIO_RUN) and g_data_wr_s
        and i_mem_wdata == 8'h40 |=> o_power_mode == MIO_IDLE)
        else $error("idle bit write did not enter idle");

    alt_phase_a: assert property (
        i_mem_wr && i_mem_addr == ADDR_G_CFG
        |=> o_sync_serial_alt_phase == $past(i_mem_wdata[G_ALT_BIT]))
        else $error("alternate phase does not follow config bit");

    restart_dly_a: assert property (
        halt_exit_s ##0 (rc_opt && st_r.g_cfg[G_DLY_BIT])
        |=> o_power_mode == MIO_RESTART && st_r.cnt == RESTART_LOAD)
        else $error("halt exit skipped the restart delay");

    g_read_zero_a: assert property (
        i_mem_rd && i_mem_addr == ADDR_G_DATA
        |=> o_mem_rvalid && o_mem_rdata[7:6] == 2'b00)
        else $error("port G special data bits read nonzero");

    g_fixed_a: assert property (
        o_port_g_oe[7:6] == 2'b00 && o_port_g_out[1] == 1'b0
        && o_port_g_oe[1] == $past(i_supervisor_fault_output))
        else $error("port G fixed pins misdriven");

    rc_wake_a: assert property (
        halt_exit_s ##0 (!(rc_opt && st_r.g_cfg[G_DLY_BIT]))
        |=> o_power_mode == MIO_RUN)
        else $error("halt wake did not resume run");

    pull_mode_a: assert property (
        o_port_c_pullup == (~o_port_c_oe & o_port_c_out)
        && o_port_l_pullup == (~o_port_l_oe & o_port_l_out))
        else $error("pull-up disagrees with config and data");

    pin_ro_a: assert property (
        i_mem_wr && i_mem_addr == ADDR_L_PIN
        |=> $stable(o_port_l_out) && $stable(o_port_l_oe))
        else $error("write to pin location changed the port");

endmodule : mio_io_ports
`default_nettype wire

// ===== verilog/mio_pin_sync.sv
// Two-stage synchroniser for the port input pins
`timescale 1ns/1ps
`default_nettype none
module mio_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } mio_sync_t;

    mio_sync_t st_r;
    mio_sync_t st_nxt;

    // ========================================================
    // First stage feeds only the second stage
    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = i_async;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_sync = st_r.sync;

endmodule : mio_pin_sync
`default_nettype wire
